/* include/csio_map.vh */
`ifndef CSIO_MAP_VH
`define CSIO_MAP_VH
// ----------------------------------------
// register offsets (plain port, word index)
// ----------------------------------------
`define CSIO_ADR_WCTL0   4'h0
`define CSIO_ADR_WCTL1   4'h1
`define CSIO_ADR_DOPC    4'h2
`define CSIO_ADR_COPC    4'h3
`define CSIO_ADR_PHPC    4'h4
`define CSIO_ADR_PERIOD  4'h5
`define CSIO_ADR_PHASE   4'h6
`define CSIO_ADR_EXTCTL  4'h7
`define CSIO_ADR_MODE    4'h8
`define CSIO_ADR_CTRL    4'h9
`define CSIO_ADR_TXBUF   4'ha
`define CSIO_ADR_RXBUF   4'hb
// ----------------------------------------
// mode register fields
// ----------------------------------------
`define CSIO_MODE_SYNC   2'h1
`define CSIO_MD_GMD_LO   0
`define CSIO_MD_CLOCK_DIRECTION    2
`define CSIO_MD_STOP_LENGTH_SEL     3
`define CSIO_MD_BIT_ORDER_SEL    4
`define CSIO_MD_IRS      5
// ----------------------------------------
// control register fields
// ----------------------------------------
`define CSIO_CR_TI       0
`define CSIO_CR_TX_SHIFT_EMPTY    1
`define CSIO_CR_RI       2
`define CSIO_CR_TE       4
`define CSIO_CR_RE       5
`define CSIO_CR_IN_POLARITY     6
`define CSIO_CR_OUT_POLARITY     7
// ----------------------------------------
// extended control fields and error bit
// ----------------------------------------
`define CSIO_EXT_RX_SHIFT_ENABLE   5
`define CSIO_RB_OVR      8
// ----------------------------------------
// reset values
// ----------------------------------------
`define CSIO_RST_8       8'h00
`define CSIO_RST_16      16'h0000
`define CSIO_RST_PERIOD  16'h0000
// ----------------------------------------
// timing
// ----------------------------------------
`define CSIO_BITS        4'h8
`define CSIO_CLK_MHZ     200
`endif

/* src/csio_core.v */
// Functional notes
// - irs 0: tx flag on buffer-to-shift load
// - irs 1: tx flag when shifting done
// - rx flag on byte into rx buffer
// - overrun if next eighth bit before read
// - rx buffer undefined after overrun
// - bit order select lsb or msb first
// - output and input polarity invert selects
// - idle output high, low if inverted
// - internal clock is base over 2(n+2)
// - divide ratio prescales count source
// - clock direction picks internal or external
// - read-only tx empty, shift empty, rx complete
// - tx enable gates both; rx needs rx enable
// - tx buffer write queues byte, clears empty
// - rx buffer holds byte plus overrun error bit
// - exactly eight data bits, no framing
// - external clock pin shifts data
`timescale 1ns/1ps
`include "csio_map.vh"
module csio_core
(
  // clock and reset
  input  wire        clk,
  input  wire        rstn,
  // register port
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  // serial pins
  output reg         serial_data_out,
  input  wire        serial_data_in,
  input  wire        serial_clock_pin_i,
  output reg         serial_clock_pin_o,
  output wire        serial_clock_pin_oe,
  // interrupt request pulses
  output reg         tx_irq_request,
  output reg         rx_irq_request
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0]  wctl0_r;      // count_clock_sel / count_divide_ratio
  reg [7:0]  wctl1_r;      // waveform_control_one
  reg [7:0]  dopc_r;       // data_out_pin_control
  reg [7:0]  copc_r;       // clock_out_pin_control
  reg [7:0]  phpc_r;       // phase_channel_control
  reg [15:0] period_r;     // bit_rate_period
  reg [15:0] phase_r;      // phase_delay_value
  reg [7:0]  ext_r;        // extended_serial_control
  reg [7:0]  mode_r;       // serial_mode_register
  reg [3:0]  cre_r;        // te, re, in_polarity, out_polarity
  reg [7:0]  txbuf_r;      // transmit_buffer
  reg        tx_empty_r;   // tx_buffer_empty
  reg [7:0]  rxbuf_r;      // received byte
  reg        rx_full_r;    // rx_complete
  reg        ovr_r;        // overrun error
  // ----------------------------------------
  // shift state
  // ----------------------------------------
  reg [7:0]  tsh_r;        // transmit shift register
  reg [3:0]  tcnt_r;       // bits left to send
  reg [7:0]  rsh_r;        // receive shift register
  reg [3:0]  rcnt_r;       // bits received
  reg        sclk_r;       // generated clock level
  reg [16:0] bdiv_r;       // bit-rate half counter, spare bit so n = ffff still counts n+2
  reg [4:0]  pdiv_r;       // prescaler counter
  reg [2:0]  ck_s_r;       // pin clock sync and history
  reg [1:0]  din_s_r;      // data in synchroniser
  wire te        = cre_r[0];
  wire re        = cre_r[1];
  wire in_polarity      = cre_r[2];
  wire out_polarity      = cre_r[3];
  wire clock_direction     = mode_r[`CSIO_MD_CLOCK_DIRECTION];
  wire msb_first = mode_r[`CSIO_MD_BIT_ORDER_SEL];
  wire tx_irq_source_sel       = mode_r[`CSIO_MD_IRS];
  wire sync_mode = (mode_r[1:0] == `CSIO_MODE_SYNC);
  wire tx_idle   = (tcnt_r == 4'h0);
  // bit order pick, used for send and receive
  function [7:0] csio_order;
    input [7:0] v;
    input       msb;
    integer     k;
    begin
      for (k = 0; k < 8; k = k + 1)
        csio_order[k] = msb ? v[7 - k] : v[k];
    end
  endfunction
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // two stages for data, three for the pin clock, before anything looks at the pins
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      // pin clock idles high, so no false edge follows reset
      ck_s_r  <= 3'h7;
      din_s_r <= 2'h0;
    end
    else
    begin
      ck_s_r  <= {ck_s_r[1:0], serial_clock_pin_i};
      din_s_r <= {din_s_r[0], serial_data_in};
    end
  end
  // ----------------------------------------
  // internal transfer clock
  // ----------------------------------------
  // prescale tick
  wire pre_tick = (pdiv_r == wctl0_r[4:0]);
  wire half_done = pre_tick && (bdiv_r == ({1'b0, period_r} + 17'h00001));
  // clock only runs while a transfer is pending, so idle level stays high
  wire run_int = sync_mode && te && (!tx_idle || !tx_empty_r);
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      pdiv_r <= 5'h00;
      bdiv_r <= 17'h00000;
      sclk_r <= 1'b1;
    end
    // a stopping clock still finishes its low half
    // so the closing rise is never a short glitch
    else if (clock_direction || !sync_mode || (!run_int && sclk_r))
    begin
      pdiv_r <= 5'h00;
      bdiv_r <= 17'h00000;
      sclk_r <= 1'b1;
    end
    else
    begin
      pdiv_r <= pre_tick ? 5'h00 : pdiv_r + 5'h01;
      if (half_done)
      begin
        bdiv_r <= 17'h00000;
        sclk_r <= ~sclk_r;
      end
      else if (pre_tick)
        bdiv_r <= bdiv_r + 17'h00001;
    end
  end
  reg sclk_d_r;
  wire sclk_now = clock_direction ? ck_s_r[2] : sclk_r;
  always @(posedge clk)
  begin
    if (!rstn)
      sclk_d_r <= 1'b1;
    else
      sclk_d_r <= sclk_now;
  end
  wire fall = sclk_d_r && !sclk_now;
  wire rise = !sclk_d_r && sclk_now;
  assign serial_clock_pin_oe = sync_mode && !clock_direction;
  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  wire wr_tb  = reg_wr && (reg_addr == `CSIO_ADR_TXBUF);
  wire rd_rb  = reg_rd && (reg_addr == `CSIO_ADR_RXBUF);
  // load at a falling edge so the first bit gets a full cell
  wire tload  = sync_mode && te && !tx_empty_r && tx_idle && fall;
  wire tshift = !tx_idle && fall;
  wire tdone  = tshift && (tcnt_r == 4'h1) && !(!tx_empty_r && te);
  // buffer byte in wire order, bit 0 goes out first
  wire [7:0] tord = csio_order(txbuf_r, msb_first);
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      tsh_r          <= `CSIO_RST_8;
      tcnt_r         <= 4'h0;
      tx_empty_r     <= 1'b1;
      serial_data_out <= 1'b1;
      tx_irq_request <= 1'b0;
    end
    else
    begin
      tx_irq_request <= 1'b0;
      if (wr_tb)
        tx_empty_r <= 1'b0;
      if (tload || (tshift && tcnt_r == 4'h1 && !tx_empty_r && te))
      begin
        tsh_r      <= tord >> 1;
        tcnt_r     <= `CSIO_BITS;
        serial_data_out <= tord[0] ^ out_polarity;
        if (!wr_tb)
          tx_empty_r <= 1'b1;
        if (!tx_irq_source_sel)
          tx_irq_request <= 1'b1;
      end
      else if (tshift)
      begin
        tcnt_r <= tcnt_r - 4'h1;
        tsh_r  <= tsh_r >> 1;
        serial_data_out <= (tcnt_r == 4'h1) ? ~out_polarity : (tsh_r[0] ^ out_polarity);
      end
      else if (tx_idle)
        serial_data_out <= ~out_polarity;
      if (tdone && tx_irq_source_sel)
        tx_irq_request <= 1'b1;
    end
  end
  // ----------------------------------------
  // receive path
  // ----------------------------------------
  // tx enable and rx enable both needed
  wire rx_on = sync_mode && te && re && ext_r[`CSIO_EXT_RX_SHIFT_ENABLE];
  wire rbit  = din_s_r[1] ^ in_polarity;
  // only rises inside a frame count; the rise after the
  // closing fall would otherwise shift the next byte
  wire rx_rise = rise && !tx_idle;
  wire rlast = rx_on && rx_rise && (rcnt_r == 4'h7);
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      rsh_r          <= `CSIO_RST_8;
      rcnt_r         <= 4'h0;
      rxbuf_r        <= `CSIO_RST_8;
      rx_full_r      <= 1'b0;
      ovr_r          <= 1'b0;
      rx_irq_request <= 1'b0;
    end
    else
    begin
      rx_irq_request <= 1'b0;
      // read clears complete; a new byte in the same cycle wins
      if (rd_rb)
      begin
        rx_full_r <= 1'b0;
        ovr_r     <= 1'b0;
      end
      if (!rx_on)
        rcnt_r <= 4'h0;
      else if (rx_rise)
      begin
        rsh_r  <= {rbit, rsh_r[7:1]};
        rcnt_r <= (rcnt_r == 4'h7) ? 4'h0 : rcnt_r + 4'h1;
      end
      if (rlast)
      begin
        rxbuf_r        <= csio_order({rbit, rsh_r[7:1]}, msb_first);
        rx_full_r      <= 1'b1;
        rx_irq_request <= 1'b1;
        if (rx_full_r && !rd_rb)
          ovr_r <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      wctl0_r  <= `CSIO_RST_8;
      wctl1_r  <= `CSIO_RST_8;
      dopc_r   <= `CSIO_RST_8;
      copc_r   <= `CSIO_RST_8;
      phpc_r   <= `CSIO_RST_8;
      period_r <= `CSIO_RST_PERIOD;
      phase_r  <= `CSIO_RST_16;
      ext_r    <= `CSIO_RST_8;
      mode_r   <= `CSIO_RST_8;
      cre_r    <= 4'h0;
      txbuf_r  <= `CSIO_RST_8;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `CSIO_ADR_WCTL0:  wctl0_r  <= reg_wdata[7:0];
        `CSIO_ADR_WCTL1:  wctl1_r  <= reg_wdata[7:0];
        `CSIO_ADR_DOPC:   dopc_r   <= reg_wdata[7:0];
        `CSIO_ADR_COPC:   copc_r   <= reg_wdata[7:0];
        `CSIO_ADR_PHPC:   phpc_r   <= reg_wdata[7:0];
        `CSIO_ADR_PERIOD: period_r <= reg_wdata;
        `CSIO_ADR_PHASE:  phase_r  <= reg_wdata;
        `CSIO_ADR_EXTCTL: ext_r    <= reg_wdata[7:0];
        `CSIO_ADR_MODE:   mode_r   <= reg_wdata[7:0];
        `CSIO_ADR_CTRL:   cre_r    <= reg_wdata[7:4];
        `CSIO_ADR_TXBUF:  txbuf_r  <= reg_wdata[7:0];
        default:          cre_r    <= cre_r;
      endcase
    end
  end
  // ----------------------------------------
  // register reads, data one cycle later
  // ----------------------------------------
  // status bits read-only
  wire [7:0] ctrl_rd = {cre_r, 1'b0, rx_full_r, tx_idle, tx_empty_r};
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      reg_rdata          <= 16'h0000;
      serial_clock_pin_o <= 1'b1;
    end
    else
    begin
      serial_clock_pin_o <= sclk_r;
      if (reg_rd)
      begin
        case (reg_addr)
          `CSIO_ADR_WCTL0:  reg_rdata <= {8'h00, wctl0_r};
          `CSIO_ADR_WCTL1:  reg_rdata <= {8'h00, wctl1_r};
          `CSIO_ADR_DOPC:   reg_rdata <= {8'h00, dopc_r};
          `CSIO_ADR_COPC:   reg_rdata <= {8'h00, copc_r};
          `CSIO_ADR_PHPC:   reg_rdata <= {8'h00, phpc_r};
          `CSIO_ADR_PERIOD: reg_rdata <= period_r;
          `CSIO_ADR_PHASE:  reg_rdata <= phase_r;
          `CSIO_ADR_EXTCTL: reg_rdata <= {8'h00, ext_r};
          `CSIO_ADR_MODE:   reg_rdata <= {8'h00, mode_r};
          `CSIO_ADR_CTRL:   reg_rdata <= {8'h00, ctrl_rd};
          `CSIO_ADR_RXBUF:  reg_rdata <= {7'h00, ovr_r, rxbuf_r};
          default:          reg_rdata <= 16'h0000;
        endcase
      end
      else
        reg_rdata <= 16'h0000;
    end
  end
endmodule

/* sim/csio_peer.sv */
`timescale 1ns/1ps
module csio_peer
(
  // serial wires
  input  wire       sck,
  input  wire       sdo,
  output reg        sdi,
  // frame control
  input  wire       arm,
  input  wire [7:0] send_byte,
  input  wire       msb,
  output reg  [7:0] got_byte
);
  integer nf = 0; // falling edges in frame
  integer nr = 0; // rising edges in frame
  initial
  begin
    sdi = 1'b1;
    got_byte = 8'h00;
  end
  // new frame restarts both counts
  always @(posedge arm)
  begin
    nf = 0;
    nr = 0;
  end
  always @(negedge sck)
  begin
    if (nf < 8)
      sdi <= send_byte[msb ? 7 - nf : nf];
    // released line must not keep the last bit
    else if (nf == 8)
      sdi <= ~sdi;
    nf = nf + 1;
  end
  always @(posedge sck)
  begin
    if (nr < 8)
      got_byte[msb ? 7 - nr : nr] <= sdo;
    nr = nr + 1;
  end
endmodule

/* sim/csio_chk_asserts.sv */
`timescale 1ns/1ps
`include "csio_map.vh"
module csio_chk
(
  // clock and reset
  input wire        clk,
  input wire        rstn,
  // register port
  input wire [3:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  // serial pins
  input wire        serial_data_out,
  input wire        serial_data_in,
  input wire        serial_clock_pin_i,
  input wire        serial_clock_pin_o,
  input wire        serial_clock_pin_oe,
  // interrupt pulses
  input wire        tx_irq_request,
  input wire        rx_irq_request
);
  reg [5:0]  mode_r; // shadow mode
  reg [3:0]  ctl_r;  // shadow te re in_polarity out_polarity
  reg [15:0] per_r;  // shadow period
  reg [4:0]  div_r;  // shadow divide
  int        lo_r;   // cycles clock low
  int        half;   // expected half period
  assign half = (div_r + 1) * (per_r + 2);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // shadows follow bus writes only
  always @(posedge clk)
  begin
    if (!rstn)
    begin
      mode_r <= 6'h00;
      ctl_r  <= 4'h0;
      per_r  <= 16'h0000;
      div_r  <= 5'h00;
    end
    else if (reg_wr)
      case (reg_addr)
        `CSIO_ADR_MODE:   mode_r <= reg_wdata[5:0];
        `CSIO_ADR_CTRL:   ctl_r  <= reg_wdata[7:4];
        `CSIO_ADR_PERIOD: per_r  <= reg_wdata;
        `CSIO_ADR_WCTL0:  div_r  <= reg_wdata[4:0];
        default:          ;
      endcase
  end
  // low phase length counter
  always @(posedge clk)
  begin
    if (!rstn || serial_clock_pin_o)
      lo_r <= 0;
    else
      lo_r <= lo_r + 1;
  end
  half_period_a: assert property ($rose(serial_clock_pin_o) && serial_clock_pin_oe |-> lo_r == half)
    else $error("clock low phase wrong");
  clk_dir_a: assert property (serial_clock_pin_oe == (mode_r[1:0] == `CSIO_MODE_SYNC && !mode_r[2]))
    else $error("clock enable wrong");
  ext_idle_a: assert property (!serial_clock_pin_oe |-> serial_clock_pin_o)
    else $error("clock made in external mode");
  tx_pulse_a: assert property (tx_irq_request |=> !tx_irq_request)
    else $error("tx request too long");
  rx_pulse_a: assert property (rx_irq_request |=> !rx_irq_request)
    else $error("rx request too long");
  rx_gate_a: assert property (rx_irq_request |-> ctl_r[1:0] == 2'h3 && mode_r[1:0] == `CSIO_MODE_SYNC)
    else $error("rx without enables");
  data_edge_a: assert property ($changed(serial_data_out) && serial_clock_pin_oe && !$past(reg_wr, 2)
    |-> !serial_clock_pin_o)
    else $error("data moved on high clock");
  idle_level_a: assert property (mode_r[1:0] == `CSIO_MODE_SYNC && !ctl_r[0] && $stable(ctl_r)
    |-> serial_data_out == !ctl_r[3])
    else $error("idle level wrong");
  cover property (rx_irq_request && mode_r[4]);
  cover property (rx_irq_request && mode_r[2]);
  cover property (tx_irq_request && mode_r[5]);
endmodule
bind csio_core csio_chk u_chk
(
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .serial_data_out(serial_data_out), .serial_data_in(serial_data_in),
  .serial_clock_pin_i(serial_clock_pin_i), .serial_clock_pin_o(serial_clock_pin_o),
  .serial_clock_pin_oe(serial_clock_pin_oe), .tx_irq_request(tx_irq_request),
  .rx_irq_request(rx_irq_request)
);

/* sim/tb_top.sv */
`timescale 1ns/1ps
`include "csio_map.vh"
module tb_top;
  // ----------------------------------------
  // stimulus and wires
  // ----------------------------------------
  reg         clk = 1'b0;
  reg         rstn = 1'b0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [15:0] reg_wdata = 16'h0000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg         ext_sck = 1'b1; // far side clock
  reg  [7:0]  pb = 8'h00;     // peer send byte
  reg         msb = 1'b0;     // peer bit order
  reg         arm = 1'b0;     // peer frame start
  wire [15:0] reg_rdata;
  wire        sdo, sdi, ck_o, ck_oe, tx_irq, rx_irq;
  wire [7:0]  got;            // byte seen by peer
  wire        sck = ck_oe ? ck_o : ext_sck;
  integer     fails = 0;
  integer     samples_checked = 0;
  integer     tx_n, rx_n, tx_at;
  always #2.5 clk = ~clk;
  // sticky pulse counts, pulses last one cycle
  always @(posedge clk)
  begin
    tx_n <= rstn ? tx_n + tx_irq : 0;
    rx_n <= rstn ? rx_n + rx_irq : 0;
  end
  csio_core dut
  (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .serial_data_out(sdo), .serial_data_in(sdi), .serial_clock_pin_i(ext_sck),
    .serial_clock_pin_o(ck_o), .serial_clock_pin_oe(ck_oe),
    .tx_irq_request(tx_irq), .rx_irq_request(rx_irq)
  );
  csio_peer peer
  (
    .sck(sck), .sdo(sdo), .sdi(sdi), .arm(arm), .send_byte(pb), .msb(msb), .got_byte(got)
  );
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chk(input [8*8:1] nm, input [15:0] e, input [15:0] g);
  begin
    samples_checked = samples_checked + 1;
    if (g !== e)
    begin
      fails = fails + 1;
      $display("[ERR] %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task wr(input [3:0] a, input [15:0] d);
  begin
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [3:0] a, output [15:0] d);
  begin
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  end
  endtask
  // bounded wait on a pulse count
  task wt(input integer n, input tx);
    integer i;
  begin
    i = 0;
    while (((tx ? tx_n : rx_n) < n) && i < 600)
    begin
      @(posedge clk);
      i = i + 1;
    end
    if (i == 600)
    begin
      fails = fails + 1;
      report_and_stop;
    end
  end
  endtask
  task setup(input [15:0] md, input [15:0] ct, input [15:0] dv);
  begin
    repeat (16) @(posedge clk); // let a trailing frame finish
    wr(`CSIO_ADR_WCTL0, dv);
    wr(`CSIO_ADR_PERIOD, 16'h0001);
    wr(`CSIO_ADR_PHASE, 16'h0000);
    wr(`CSIO_ADR_EXTCTL, 16'h0020);
    wr(`CSIO_ADR_MODE, md);
    wr(`CSIO_ADR_CTRL, ct & 16'h00c0);
    repeat (24) @(posedge clk);
    chk("idle", {15'h0000, ~ct[7]}, {15'h0000, sdo});
    wr(`CSIO_ADR_CTRL, ct);
  end
  endtask
  // one byte each way, waits both requests
  task xfer(input [7:0] t, input [7:0] p, input ext);
    integer k, r0, t0;
  begin
    r0 = rx_n;
    t0 = tx_n;
    pb = p;
    arm = 1'b1;
    #1 arm = 1'b0;
    wr(`CSIO_ADR_TXBUF, {8'h00, t});
    // nine falls: eight bits plus the closing fall
    for (k = 0; k < 18 && ext; k = k + 1)
    begin
      repeat (10) @(posedge clk);
      ext_sck <= ~ext_sck;
    end
    wt(r0 + 1, 1'b0);
    tx_at = tx_n - t0;
    wt(t0 + 1, 1'b1);
  end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    reg [15:0] d;
  begin
    chk("pins", 16'h000c, {12'h000, sdo, ck_o, tx_irq, rx_irq});
    rd(4'hf, d);
    chk("unmapped", 16'h0000, d);
    wr(`CSIO_ADR_PERIOD, 16'hbeef);
    rd(`CSIO_ADR_PERIOD, d);
    chk("period", 16'hbeef, d);
  end
  endtask
  task t_lsb;
    reg [15:0] d;
  begin
    setup(16'h0001, 16'h0030, 16'h0000);
    xfer(8'ha5, 8'h3c, 1'b0);
    chk("txirq0", 16'h0001, tx_at[15:0]);
    chk("lsb tx", 16'h00a5, {8'h00, got});
    rd(`CSIO_ADR_RXBUF, d);
    chk("lsb rx", 16'h003c, d);
  end
  endtask
  task t_msb;
    reg [15:0] d;
  begin
    msb = 1'b1;
    setup(16'h0031, 16'h00f0, 16'h0000);
    xfer(8'h96, 8'h41, 1'b0);
    chk("txirq1", 16'h0000, tx_at[15:0]);
    chk("msb tx", 16'h0069, {8'h00, got});
    rd(`CSIO_ADR_CTRL, d);
    chk("status", 16'h00f7, d);
    rd(`CSIO_ADR_RXBUF, d);
    chk("msb rx", 16'h00be, d);
  end
  endtask
  task t_ovr;
    reg [15:0] d;
  begin
    msb = 1'b0;
    setup(16'h0001, 16'h0030, 16'h0001);
    xfer(8'h11, 8'h22, 1'b0);
    xfer(8'h33, 8'h44, 1'b0);
    rd(`CSIO_ADR_RXBUF, d);
    chk("ovr", 16'h0100, d & 16'h0100);
    rd(`CSIO_ADR_RXBUF, d);
    chk("ovr clr", 16'h0000, d & 16'h0100);
  end
  endtask
  task t_ext;
    reg [15:0] d;
  begin
    setup(16'h0005, 16'h0030, 16'h0000);
    chk("oe", 16'h0000, {15'h0000, ck_oe});
    xfer(8'hc3, 8'h5a, 1'b1);
    chk("ext tx", 16'h00c3, {8'h00, got});
    rd(`CSIO_ADR_RXBUF, d);
    chk("ext rx", 16'h005a, d);
  end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset;
    t_lsb;
    t_msb;
    t_ovr;
    t_ext;
    report_and_stop;
  end
endmodule
